// File: src/asp_serial_port.sv
// Serial port of the converter with its control register fields
// How it works
// - Append status byte to data reads when set
// - Chip-select-use clear means three-wire, CS only gates the output
// - Three-wire: interface resets on final rising clock
// - Three-wire: output released after final read clock
// - Release timing adjustable by delay select field
// - Appended status lengthens word; host counts it
// - CS high always tristates output, even three-wire
// - Chip-select-use set means four-wire, CS frames
// - Four-wire: interface resets on CS rising
// - Four-wire: output becomes data ready after CS
// - Fault flags only raised in four-wire mode
// - Four-wire: output tristated while CS high
// - Reference on presents selected level at pin
// - Reference-on field resets to zero
// - Delay select: 10 ns or 100 ns release
// - Level select zero high, one low level
`timescale 1ns/100ps
`default_nettype none
`include "asp_params.svh"

module asp_serial_port import asp_pkg::*; (
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire logic i_sclk,
	input wire logic i_cs_n,
	input wire logic i_sdi,
	input wire logic i_drdy_on_dout,
	input wire logic [15:0] i_result,
	input wire logic [3:0] i_channel,
	input wire logic i_result_valid,
	output logic o_sdo,
	output logic o_sdo_oe_n,
	output logic o_int_n,
	output logic o_ref_enable,
	output logic o_ref_low_select,
	output logic o_bipolar
);
	// ------------------------------------------------------------------
	// Pin synchronisers and edge finding
	// ------------------------------------------------------------------
	logic sclk_s, cs_s, sdi_s;
	logic sclk_d_reg, cs_d_reg;
	logic sclk_rise, cs_rise;

	asp_sync2 u_sync_sclk (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
		.i_rst_val(1'b1), .i_async(i_sclk), .o_sync(sclk_s));
	asp_sync2 u_sync_cs (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
		.i_rst_val(1'b1), .i_async(i_cs_n), .o_sync(cs_s));
	asp_sync2 u_sync_sdi (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
		.i_rst_val(1'b0), .i_async(i_sdi), .o_sync(sdi_s));

	// Delayed copies for edge detection
	always_ff @(posedge i_ref_clk) begin
		sclk_d_reg <= i_resetn ? sclk_s : 1'b1;
		cs_d_reg <= i_resetn ? cs_s : 1'b1;
	end

	assign sclk_rise = sclk_s && !sclk_d_reg;
	assign cs_rise = cs_s && !cs_d_reg;

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	asp_state_t state_reg, state_next;
	logic [5:0] cnt_reg, cnt_next;
	logic [7:0] cmd_reg, cmd_next;
	logic [23:0] in_reg, in_next;
	logic [23:0] out_reg, out_next;
	logic [15:0] ctrl_reg, ctrl_next;
	logic [15:0] data_reg, data_next;
	logic [3:0] chan_reg, chan_next;
	logic nrdy_reg, nrdy_next;
	logic [2:0] flt_reg, flt_next;
	logic [3:0] rel_reg, rel_next;

	logic four_wire, active, is_read, final_rise;
	logic [5:0] frame_len;
	logic [5:0] addr;
	logic [7:0] status_byte;
	logic [2:0] flt_set, flt_clr;

	assign four_wire = ctrl_reg[`ASP_CS_USE_BIT];
	assign active = four_wire ? !cs_s : 1'b1;
	assign addr = cmd_reg[5:0];
	assign is_read = cmd_reg[`ASP_CMD_READ_BIT];
	assign status_byte = {nrdy_reg, flt_reg, chan_reg};

	// Frame length from the addressed register and append field
	always_comb begin
		case (addr)
		`ASP_ADDR_CONTROL: frame_len = `ASP_LEN_16;
		`ASP_ADDR_DATA: frame_len = ctrl_reg[`ASP_APPEND_BIT] ?
			`ASP_LEN_24 : `ASP_LEN_16;
		default: frame_len = `ASP_LEN_8;
		endcase
	end

	assign final_rise = sclk_rise && active && state_reg == ASP_DATA &&
		cnt_reg == frame_len - 6'd1;

	// ------------------------------------------------------------------
	// Frame engine: next values
	// ------------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		cmd_next = cmd_reg;
		in_next = in_reg;
		out_next = out_reg;
		ctrl_next = ctrl_reg;
		rel_next = (rel_reg != 4'h0) ? rel_reg - 4'h1 : 4'h0;
		flt_set = 3'b000;
		flt_clr = 3'b000;
		if (four_wire && cs_rise) begin
			// Chip select rising ends and resets the frame
			state_next = ASP_IDLE;
			cnt_next = 6'd0;
			if (state_reg == ASP_CMD || state_reg == ASP_DATA) begin
				flt_set[0] = 1'b1;
			end
		end else if (sclk_rise && active) begin
			in_next = {in_reg[22:0], sdi_s};
			cnt_next = cnt_reg + 6'd1;
			case (state_reg)
			ASP_IDLE, ASP_CMD: begin
				state_next = ASP_CMD;
				if (cnt_reg == 6'd7) begin
					cmd_next = {in_reg[6:0], sdi_s};
					state_next = ASP_DATA;
					// Snapshot of the read word, left aligned
					case ({in_reg[5:0], sdi_s} & 7'h3f)
					7'(`ASP_ADDR_STATUS): out_next = {status_byte, 16'h0000};
					7'(`ASP_ADDR_CONTROL): out_next = {ctrl_reg, 8'h00};
					7'(`ASP_ADDR_DATA): out_next = {data_reg, status_byte};
					default: out_next = 24'h000000;
					endcase
				end
			end
			ASP_DATA: begin
				out_next = {out_reg[22:0], 1'b0};
				if (final_rise) begin
					if (!is_read && addr == `ASP_ADDR_CONTROL) begin
						ctrl_next = {in_reg[14:0], sdi_s} & `ASP_CTRL_WMASK;
					end else if (!is_read) begin
						flt_set[2] = four_wire;
					end else if (addr > `ASP_ADDR_DATA) begin
						flt_set[1] = four_wire;
					end
					if (is_read && addr == `ASP_ADDR_STATUS) begin
						flt_clr = 3'b111;
					end
					if (four_wire) begin
						state_next = ASP_DONE;
					end else begin
						state_next = ASP_IDLE;
						cnt_next = 6'd0;
						if (is_read) begin
							// Keep driving the output for the selected delay
							rel_next = ctrl_reg[`ASP_REL_DEL_BIT] ?
								4'(`ASP_REL_LONG_CYC) :
								4'(`ASP_REL_SHORT_CYC);
						end
					end
				end
			end
			ASP_DONE: begin
				cnt_next = cnt_reg;
				flt_set[0] = 1'b1;
			end
			default: state_next = ASP_IDLE;
			endcase
		end
		// Set wins over the clear from a status read
		flt_next = (flt_reg & ~flt_clr) | flt_set;
		if (!i_resetn) begin
			state_next = ASP_IDLE;
			cnt_next = 6'd0;
			cmd_next = 8'h00;
			in_next = 24'h000000;
			out_next = 24'h000000;
			ctrl_next = `ASP_CTRL_RESET;
			rel_next = 4'h0;
			flt_next = 3'b000;
		end
	end

	// Frame engine registers
	always_ff @(posedge i_ref_clk) begin
		state_reg <= state_next;
		cnt_reg <= cnt_next;
		cmd_reg <= cmd_next;
		in_reg <= in_next;
		out_reg <= out_next;
		ctrl_reg <= ctrl_next;
		rel_reg <= rel_next;
		flt_reg <= flt_next;
	end

	// ------------------------------------------------------------------
	// Result holding and data ready
	// ------------------------------------------------------------------
	always_comb begin
		data_next = data_reg;
		chan_next = chan_reg;
		nrdy_next = nrdy_reg;
		if (final_rise && is_read && addr == `ASP_ADDR_DATA) begin
			nrdy_next = 1'b1;
		end
		// A new result wins over the read that clears ready
		if (i_result_valid) begin
			data_next = i_result;
			chan_next = i_channel;
			nrdy_next = 1'b0;
		end
		if (!i_resetn) begin
			data_next = 16'h0000;
			chan_next = 4'h0;
			nrdy_next = 1'b1;
		end
	end

	// Result registers
	always_ff @(posedge i_ref_clk) begin
		data_reg <= data_next;
		chan_reg <= chan_next;
		nrdy_reg <= nrdy_next;
	end

	// ------------------------------------------------------------------
	// Pin drive
	// ------------------------------------------------------------------
	logic rd_phase;
	// Four-wire read data stands until chip select rises
	assign rd_phase = ((state_reg == ASP_DATA || state_reg == ASP_DONE) &&
		is_read) || rel_reg != 4'h0;

	// Read data while shifting, data ready between frames
	assign o_sdo = rd_phase ? out_reg[23] : nrdy_reg;
	assign o_sdo_oe_n = cs_s || !(rd_phase ||
		(four_wire && i_drdy_on_dout && state_reg != ASP_DATA));
	assign o_int_n = i_drdy_on_dout ? 1'b1 : nrdy_reg;
	assign o_ref_enable = ctrl_reg[`ASP_REF_ON_BIT];
	assign o_ref_low_select = ctrl_reg[`ASP_REF_VAL_BIT];
	assign o_bipolar = ctrl_reg[14];

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	sequence read_end_s;
		final_rise && !four_wire && is_read;
	endsequence

	sequence hold_low_s;
		!cs_s [*2];
	endsequence

	cs_tristate_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		cs_s |-> o_sdo_oe_n)
		else $error("output driven while chip select high");

	ctrl_reset_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		$rose(i_resetn) |-> ctrl_reg == 16'h4000 && !o_ref_enable)
		else $error("control register reset value wrong");

	cs_frame_reset_a: assert property (@(posedge i_ref_clk)
		disable iff (!i_resetn)
		four_wire && cs_rise |=> state_reg == ASP_IDLE && cnt_reg == 6'd0)
		else $error("frame not reset on chip select rise");

	last_clock_reset_a: assert property (@(posedge i_ref_clk)
		disable iff (!i_resetn)
		final_rise && !four_wire |=> state_reg == ASP_IDLE)
		else $error("three-wire frame not reset on last clock");

	short_release_a: assert property (@(posedge i_ref_clk)
		disable iff (!i_resetn)
		read_end_s ##0 !ctrl_reg[12] ##1 hold_low_s
		|-> o_sdo_oe_n)
		else $error("short output release late");

	long_release_a: assert property (@(posedge i_ref_clk)
		disable iff (!i_resetn)
		read_end_s ##0 ctrl_reg[12] ##1 hold_low_s
		|-> !o_sdo_oe_n ##9 (o_sdo_oe_n || cs_s))
		else $error("long output release wrong");

	append_len_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		final_rise && addr == 6'h02 |->
		cnt_reg == (ctrl_reg[10] ? 6'd31 : 6'd23))
		else $error("data frame length wrong");

	fault_mode_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		flt_reg != 3'b000 && $past(flt_reg) == 3'b000 |->
		$past(four_wire))
		else $error("fault raised in three-wire mode");

	drdy_switch_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		four_wire && cs_rise && i_drdy_on_dout && rel_reg == 4'h0 |=>
		o_sdo == nrdy_reg)
		else $error("output not data ready after frame");

	ref_write_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		final_rise && !is_read && addr == 6'h01 |=>
		o_ref_enable == $past(in_reg[7]) &&
		o_ref_low_select == $past(in_reg[12]))
		else $error("reference controls not updated");
endmodule : asp_serial_port

`default_nettype wire

// File: inc/asp_params.svh
// Offsets, field positions, reset values and timing counts of the port
`ifndef ASP_PARAMS_SVH
`define ASP_PARAMS_SVH

// ----------------------------------------------------------------------
// Register addresses (six-bit field of the command byte)
// ----------------------------------------------------------------------
`define ASP_ADDR_STATUS 6'h00
`define ASP_ADDR_CONTROL 6'h01
`define ASP_ADDR_DATA 6'h02

// ----------------------------------------------------------------------
// Command byte layout
// ----------------------------------------------------------------------
`define ASP_CMD_READ_BIT 6

// ----------------------------------------------------------------------
// Converter control fields and reset value
// ----------------------------------------------------------------------
`define ASP_CTRL_RESET 16'h4000
`define ASP_CTRL_WMASK 16'h7fff
`define ASP_REF_VAL_BIT 13
`define ASP_REL_DEL_BIT 12
`define ASP_APPEND_BIT 10
`define ASP_CS_USE_BIT 9
`define ASP_REF_ON_BIT 8

// ----------------------------------------------------------------------
// Status byte fields
// ----------------------------------------------------------------------
`define ASP_ST_NRDY_BIT 7
`define ASP_ST_WFLT_BIT 6
`define ASP_ST_RFLT_BIT 5
`define ASP_ST_CFLT_BIT 4

// ----------------------------------------------------------------------
// Frame lengths in clocks, command byte included
// ----------------------------------------------------------------------
`define ASP_LEN_8 6'd16
`define ASP_LEN_16 6'd24
`define ASP_LEN_24 6'd32

// ----------------------------------------------------------------------
// Output release delay, times in ns and counts at the clock rate
// ----------------------------------------------------------------------
`define ASP_CLK_NS 10
`define ASP_REL_SHORT_NS 10
`define ASP_REL_LONG_NS 100
`define ASP_REL_SHORT_CYC (`ASP_REL_SHORT_NS / `ASP_CLK_NS)
`define ASP_REL_LONG_CYC (`ASP_REL_LONG_NS / `ASP_CLK_NS)

`endif

// File: inc/asp_pkg.sv
// Types shared by the serial port control design
package asp_pkg;
	// Serial frame states, Gray along idle-command-data-done
	typedef enum logic [1:0] {
		ASP_IDLE = 2'b00,
		ASP_CMD = 2'b01,
		ASP_DATA = 2'b11,
		ASP_DONE = 2'b10
	} asp_state_t;
endpackage : asp_pkg

// File: src/asp_sync2.sv
// Two-flop synchroniser for one pin level
`timescale 1ns/100ps
`default_nettype none

module asp_sync2 (
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire logic i_rst_val,
	input wire logic i_async,
	output logic o_sync
);
	logic meta_reg;
	logic sync_reg;
	logic meta_next;
	logic sync_next;

	// Next values, reset level chosen by the instance
	always_comb begin
		meta_next = i_async;
		sync_next = meta_reg;
		if (!i_resetn) begin
			meta_next = i_rst_val;
			sync_next = i_rst_val;
		end
	end

	// Register stage
	always_ff @(posedge i_ref_clk) begin
		meta_reg <= meta_next;
		sync_reg <= sync_next;
	end

	assign o_sync = sync_reg;
endmodule : asp_sync2

`default_nettype wire

// File: verification/asp_host_model.sv
// Host controller model driving the serial port pins
`timescale 1ns/100ps
`default_nettype none

module asp_host_model (
	input wire logic i_ref_clk,
	input wire logic i_sdo,
	output logic o_sclk,
	output logic o_cs_n,
	output logic o_sdi
);
	logic [23:0] rd_data;
	event rd_ev;
	// Idle pins: clock high, deselected
	initial begin
		o_sclk = 1'b1;
		o_cs_n = 1'b1;
		o_sdi = 1'b1;
		rd_data = 24'h0;
	end
	// ----
	// Serial clock of 160 ns, changes at ref clock falls
	// ----
	task automatic half();
		repeat (8) @(negedge i_ref_clk);
	endtask : half
	// Chip select level, held low for three-wire traffic
	task automatic set_cs(input logic v);
		@(negedge i_ref_clk);
		o_cs_n = v;
	endtask : set_cs
	// Command then n bits, MSB first; returns soon after last rise
	task automatic frame(input logic four, input logic [7:0] cmd,
		input int n, input logic [23:0] wd, input logic rd);
		logic [31:0] sh;
		logic [23:0] got;
		sh = {cmd, wd << (24 - n)};
		got = 24'h0;
		if (four)
			o_cs_n = 1'b0;
		half();
		for (int i = 0; i < 8 + n; i++) begin
			o_sclk = 1'b0;
			o_sdi = sh[31];
			sh = sh << 1;
			half();
			o_sclk = 1'b1;
			got = {got[22:0], i_sdo};
			if (i < 7 + n)
				half();
		end
		if (rd) begin
			rd_data = got & ~(24'hffffff << n);
			->rd_ev;
		end
		// Data line leaves the last bit once it is no longer sampled
		repeat (3) @(negedge i_ref_clk);
		o_sdi = ~o_sdi;
		if (four) begin
			half();
			o_cs_n = 1'b1;
			// Deselect long enough for the port to see the rise
			half();
		end
	endtask : frame
endmodule : asp_host_model
`default_nettype wire

// File: verification/testbench.sv
// Self-checking bench for the converter serial port
`timescale 1ns/100ps
`default_nettype none
`include "asp_params.svh"

module testbench;
	logic i_ref_clk = 1'b0;
	logic i_resetn;
	logic i_drdy_on_dout;
	logic [15:0] i_result;
	logic [3:0] i_channel;
	logic i_result_valid;
	logic sclk, cs_n, sdi, o_sdo, o_sdo_oe_n, o_int_n;
	logic o_ref_enable, o_ref_low_select, lv, o_bipolar, sdo_pin;
	logic [23:0] exp_q[$];
	logic [15:0] ctl;
	int n_mismatch = 0;
	int tests_run = 0;
	int cyc = 0;

	asp_serial_port dut_u (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
		.i_sclk(sclk), .i_cs_n(cs_n), .i_sdi(sdi),
		.i_drdy_on_dout(i_drdy_on_dout), .i_result(i_result),
		.i_channel(i_channel), .i_result_valid(i_result_valid),
		.o_sdo(o_sdo), .o_sdo_oe_n(o_sdo_oe_n), .o_int_n(o_int_n),
		.o_ref_enable(o_ref_enable), .o_ref_low_select(o_ref_low_select),
		.o_bipolar(o_bipolar));
	// Released data pin floats to its pull-up level
	assign sdo_pin = o_sdo_oe_n ? 1'b1 : o_sdo;
	asp_host_model host_u (.i_ref_clk(i_ref_clk), .i_sdo(sdo_pin),
		.o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi));

	always #5 i_ref_clk = ~i_ref_clk;

	// ----
	// Compare, report and bus tasks
	// ----
	task automatic check(input string nm, input logic [23:0] e,
		input logic [23:0] g);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : check
	task automatic complete_run();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : complete_run
	task automatic idle(input int k);
		repeat (k) @(negedge i_ref_clk);
	endtask : idle
	task automatic rd(input logic four, input logic [5:0] a, input int n,
		input logic [23:0] e);
		exp_q.push_back(e);
		host_u.frame(four, {2'b01, a}, n, 24'h0, 1'b1);
	endtask : rd
	task automatic wr(input logic four, input logic [5:0] a, input int n,
		input logic [23:0] d);
		host_u.frame(four, {2'b00, a}, n, d, 1'b0);
		idle(6);
	endtask : wr
	// Fresh conversion result with random value and channel
	task automatic new_result();
		@(negedge i_ref_clk);
		i_result = 16'($urandom);
		i_channel = 4'($urandom);
		i_result_valid = 1'b1;
		@(negedge i_ref_clk);
		i_result_valid = 1'b0;
		idle(2);
	endtask : new_result

	// Pairs each finished read with the oldest expected word
	always @(host_u.rd_ev) begin
		if (exp_q.size() == 0)
			check("read_queue", 24'h1, 24'h0);
		else
			check("read_word", exp_q.pop_front(), host_u.rd_data);
	end

	// Hang guard
	always @(posedge i_ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			complete_run();
		end
	end

	initial begin
		i_resetn = 1'b0;
		i_drdy_on_dout = 1'b0;
		i_result = 16'h0000;
		i_channel = 4'h0;
		i_result_valid = 1'b0;
		void'($urandom(25));
		idle(10);
		i_resetn = 1'b1;
		idle(4);
		check("ref_enable", 24'h0, 24'(o_ref_enable));
		check("bipolar", 24'h1, 24'(o_bipolar));
		host_u.set_cs(1'b0);
		rd(1'b0, `ASP_ADDR_CONTROL, 16, 24'(`ASP_CTRL_RESET));
		lv = 1'($urandom);
		ctl = 16'hc100 | (16'(lv) << `ASP_REF_VAL_BIT);
		wr(1'b0, `ASP_ADDR_CONTROL, 16, 24'(ctl));
		ctl[15] = 1'b0;
		check("ref_enable", 24'h1, 24'(o_ref_enable));
		check("ref_low", 24'(lv), 24'(o_ref_low_select));
		rd(1'b0, `ASP_ADDR_CONTROL, 16, 24'(ctl));
		// Short and long output release after a data read
		for (int d = 0; d < 2; d++) begin
			ctl[`ASP_REL_DEL_BIT] = d[0];
			wr(1'b0, `ASP_ADDR_CONTROL, 16, 24'(ctl));
			new_result();
			check("int_n", 24'h0, 24'(o_int_n));
			rd(1'b0, `ASP_ADDR_DATA, 16, 24'(i_result));
			idle(4);
			check("sdo_oe_n", 24'(d == 0), 24'(o_sdo_oe_n));
			idle(11);
			check("sdo_oe_n", 24'h1, 24'(o_sdo_oe_n));
			check("int_n", 24'h1, 24'(o_int_n));
		end
		new_result();
		rd(1'b0, `ASP_ADDR_DATA, 16, 24'(i_result));
		host_u.set_cs(1'b1);
		idle(5);
		check("sdo_oe_n", 24'h1, 24'(o_sdo_oe_n));
		host_u.set_cs(1'b0);
		ctl[`ASP_APPEND_BIT] = 1'b1;
		wr(1'b0, `ASP_ADDR_CONTROL, 16, 24'(ctl));
		new_result();
		rd(1'b0, `ASP_ADDR_DATA, 24, {i_result, 4'h0, i_channel});
		wr(1'b0, `ASP_ADDR_STATUS, 8, 24'h0);
		rd(1'b0, `ASP_ADDR_STATUS, 8, {16'h0, 4'h8, i_channel});
		// Four-wire framing with data ready on the output pin
		ctl[`ASP_CS_USE_BIT] = 1'b1;
		wr(1'b0, `ASP_ADDR_CONTROL, 16, 24'(ctl));
		host_u.set_cs(1'b1);
		i_drdy_on_dout = 1'b1;
		new_result();
		check("sdo_oe_n", 24'h1, 24'(o_sdo_oe_n));
		host_u.set_cs(1'b0);
		idle(5);
		check("sdo_ready", 24'h0, 24'({o_sdo, o_sdo_oe_n}));
		rd(1'b1, `ASP_ADDR_DATA, 24, {i_result, 4'h0, i_channel});
		idle(5);
		check("sdo_oe_n", 24'h1, 24'(o_sdo_oe_n));
		host_u.set_cs(1'b0);
		idle(5);
		check("sdo_ready", 24'h2, 24'({o_sdo, o_sdo_oe_n}));
		host_u.frame(1'b1, 8'h01, 4, 24'h0, 1'b0);
		wr(1'b1, `ASP_ADDR_STATUS, 8, 24'h0);
		rd(1'b1, 6'h07, 8, 24'h0);
		rd(1'b1, `ASP_ADDR_CONTROL, 16, 24'(ctl));
		rd(1'b1, `ASP_ADDR_STATUS, 8, {16'h0, 4'hf, i_channel});
		rd(1'b1, `ASP_ADDR_STATUS, 8, {16'h0, 4'h8, i_channel});
		// One clock too many after a full status frame
		host_u.frame(1'b1, 8'h40, 9, 24'h0, 1'b0);
		rd(1'b1, `ASP_ADDR_STATUS, 8, {16'h0, 4'h9, i_channel});
		idle(5);
		check("pending_reads", 24'h0, 24'(exp_q.size()));
		complete_run();
	end
endmodule : testbench
`default_nettype wire
